//--- tsc_pkg.sv
// package for the timestamp correction register bank: offsets, layouts, reset values, carriers
// assumes the bank sits on the mac control port, which carries dword offsets and 32-bit data
package tsc_pkg;

    // ************************************************************
    // register map, dword offsets (byte address is four times these)
    // ************************************************************
    localparam logic [7:0] TSC_TX_STEP_IDX = 8'hD0;
    localparam logic [7:0] TSC_TX_FNS_IDX = 8'hD1;
    localparam logic [7:0] TSC_TX_NS_IDX = 8'hD2;
    localparam logic [7:0] TSC_RX_STEP_IDX = 8'hD3;
    localparam logic [7:0] TSC_RX_FNS_IDX = 8'hD4;
    localparam logic [7:0] TSC_RX_NS_IDX = 8'hD5;
    localparam int TSC_BYTES_PER_REG = 4;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int TSC_FRAC_LSB = 0;
    localparam int TSC_FRAC_W = 16;
    localparam int TSC_WHOLE_LSB = 16;
    localparam int TSC_WHOLE_W = 9;
    localparam int TSC_STEP_W = 25;
    localparam int TSC_OFS_W = 16;
    localparam int TSC_STAGE_W = 4;

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic [TSC_STEP_W-1:0] TSC_STEP_RST = 25'h0000000;
    localparam logic [TSC_OFS_W-1:0] TSC_OFS_RST = 16'h0000;
    localparam logic [31:0] TSC_RDATA_RST = 32'h00000000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tsc_bus_req_t;

    typedef struct packed {
        logic [31:0] ns;
        logic [15:0] fns;
    } tsc_stamp_t;

    typedef struct packed {
        logic [TSC_STEP_W-1:0] step;
        logic [TSC_OFS_W-1:0] fns_ofs;
        logic [TSC_OFS_W-1:0] ns_ofs;
    } tsc_dir_cfg_t;

endpackage

//--- tsc_correction_regs.sv
// timestamp correction register bank with the per-direction correction adders
// assumes a single-cycle control port on ref_clk and timestamps from logic on the same clock
// assumes stage counts are static levels from the same clock, so they pass no synchroniser

`timescale 1ns/1ns
`default_nettype none

module tsc_correction_regs
    import tsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire tsc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic [TSC_STAGE_W-1:0] tx_stage_count,
    input wire logic [TSC_STAGE_W-1:0] rx_stage_count,
    input wire logic tx_stamp_valid,
    input wire tsc_stamp_t tx_stamp_in,
    input wire logic rx_stamp_valid,
    input wire tsc_stamp_t rx_stamp_in,
    output logic tx_corr_valid,
    output tsc_stamp_t tx_corr_stamp,
    output logic rx_corr_valid,
    output tsc_stamp_t rx_corr_stamp
);

    // ************************************************************
    // helpers
    // ************************************************************

    // a step register image: fraction low, whole ns above, top bits zero
    function automatic logic [31:0] step_word(input logic [TSC_STEP_W-1:0] step);
        step_word = {7'h00, step};
    endfunction

    // offsets sit in the low half; the upper half never stores anything
    function automatic logic [31:0] ofs_word(input logic [TSC_OFS_W-1:0] ofs);
        ofs_word = {16'h0000, ofs};
    endfunction

    // correction in one 48-bit fixed point sum so the fraction carry lands in ns
    function automatic tsc_stamp_t apply_corr(
        input tsc_stamp_t stamp,
        input tsc_dir_cfg_t cfg,
        input logic [TSC_STAGE_W-1:0] stages
    );
        logic [47:0] scaled;
        logic [47:0] ofs;
        logic [47:0] sum;
        logic [TSC_STEP_W+TSC_STAGE_W-1:0] prod;
        // both factors are widened to the product width so no top bit is lost
        prod = {4'h0, cfg.step} * {25'h0000000, stages};
        scaled = {19'h00000, prod};
        // whole ns offset above the fraction, both taken as unsigned
        ofs = {16'h0000, cfg.ns_ofs, cfg.fns_ofs};
        // the sum wraps at 48 bits, so a stamp near the top of the ns range rolls over
        sum = stamp + scaled + ofs;
        apply_corr = sum;
    endfunction

    // ************************************************************
    // register state
    // ************************************************************
    // one struct per direction keeps the three fields of a path together
    tsc_dir_cfg_t tx_cfg;
    tsc_dir_cfg_t rx_cfg;
    tsc_dir_cfg_t next_tx_cfg;
    tsc_dir_cfg_t next_rx_cfg;
    logic [31:0] next_bus_rdata;
    logic next_bus_rvalid;

    // ************************************************************
    // write decode
    // ************************************************************
    // writes take the whole word; only the implemented field bits are kept
    // a write lands at the edge that takes it, so a read in that cycle sees the old word
    always_comb begin
        next_tx_cfg = tx_cfg;
        next_rx_cfg = rx_cfg;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                TSC_TX_STEP_IDX: begin
                    next_tx_cfg.step = bus_req.wdata[TSC_STEP_W-1:0];
                end
                TSC_TX_FNS_IDX: begin
                    next_tx_cfg.fns_ofs = bus_req.wdata[TSC_OFS_W-1:0];
                end
                TSC_TX_NS_IDX: begin
                    next_tx_cfg.ns_ofs = bus_req.wdata[TSC_OFS_W-1:0];
                end
                TSC_RX_STEP_IDX: begin
                    next_rx_cfg.step = bus_req.wdata[TSC_STEP_W-1:0];
                end
                TSC_RX_FNS_IDX: begin
                    next_rx_cfg.fns_ofs = bus_req.wdata[TSC_OFS_W-1:0];
                end
                TSC_RX_NS_IDX: begin
                    next_rx_cfg.ns_ofs = bus_req.wdata[TSC_OFS_W-1:0];
                end
                default: begin
                    // other offsets belong to other banks of the mac
                end
            endcase
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    // read data is registered; unmapped offsets answer zero rather than hold the bus
    // unused bits answer zero because no flop stores them
    always_comb begin
        next_bus_rvalid = bus_req.rd;
        next_bus_rdata = TSC_RDATA_RST;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                TSC_TX_STEP_IDX: begin
                    next_bus_rdata = step_word(tx_cfg.step);
                end
                TSC_TX_FNS_IDX: begin
                    next_bus_rdata = ofs_word(tx_cfg.fns_ofs);
                end
                TSC_TX_NS_IDX: begin
                    next_bus_rdata = ofs_word(tx_cfg.ns_ofs);
                end
                TSC_RX_STEP_IDX: begin
                    next_bus_rdata = step_word(rx_cfg.step);
                end
                TSC_RX_FNS_IDX: begin
                    next_bus_rdata = ofs_word(rx_cfg.fns_ofs);
                end
                TSC_RX_NS_IDX: begin
                    next_bus_rdata = ofs_word(rx_cfg.ns_ofs);
                end
                default: begin
                    next_bus_rdata = TSC_RDATA_RST;
                end
            endcase
        end
    end

    // ************************************************************
    // register flops
    // ************************************************************
    // hardware reset clears every field; the bank has no software reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cfg <= '{TSC_STEP_RST, TSC_OFS_RST, TSC_OFS_RST};
            rx_cfg <= '{TSC_STEP_RST, TSC_OFS_RST, TSC_OFS_RST};
            bus_rdata <= TSC_RDATA_RST;
            bus_rvalid <= 1'b0;
        end else begin
            tx_cfg <= next_tx_cfg;
            rx_cfg <= next_rx_cfg;
            bus_rdata <= next_bus_rdata;
            bus_rvalid <= next_bus_rvalid;
        end
    end

    // ************************************************************
    // correction adders
    // ************************************************************
    // one register stage per direction; the multiply and 48-bit add share that cycle,
    // which is cheap at this clock but would want a split stage at line rate
    logic next_tx_corr_valid;
    logic next_rx_corr_valid;
    tsc_stamp_t next_tx_corr_stamp;
    tsc_stamp_t next_rx_corr_stamp;

    // config is the registered copy, so a write in the stamp's cycle applies to the next one
    // the stamp outputs hold between pulses so a slow reader can still pick them up
    always_comb begin
        next_tx_corr_valid = tx_stamp_valid;
        next_rx_corr_valid = rx_stamp_valid;
        next_tx_corr_stamp = tx_corr_stamp;
        next_rx_corr_stamp = rx_corr_stamp;
        if (tx_stamp_valid) begin
            next_tx_corr_stamp = apply_corr(tx_stamp_in, tx_cfg, tx_stage_count);
        end
        if (rx_stamp_valid) begin
            next_rx_corr_stamp = apply_corr(rx_stamp_in, rx_cfg, rx_stage_count);
        end
    end

    // ************************************************************
    // stamp flops
    // ************************************************************
    // reset clears the stamps too, so a stale stamp never survives a reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_corr_valid <= 1'b0;
            rx_corr_valid <= 1'b0;
            tx_corr_stamp <= '0;
            rx_corr_stamp <= '0;
        end else begin
            tx_corr_valid <= next_tx_corr_valid;
            rx_corr_valid <= next_rx_corr_valid;
            tx_corr_stamp <= next_tx_corr_stamp;
            rx_corr_stamp <= next_rx_corr_stamp;
        end
    end

endmodule

`default_nettype wire

//--- tsc_regs_props.sv
// checker for the timestamp correction register bank, ports only
// assumes it is bound to tsc_correction_regs on a single ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module tsc_regs_props
    import tsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire tsc_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic tx_stamp_valid,
    input wire logic rx_stamp_valid,
    input wire logic tx_corr_valid,
    input wire logic rx_corr_valid,
    input wire tsc_stamp_t tx_corr_stamp,
    input wire tsc_stamp_t rx_corr_stamp
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_read;
        bus_req.rd;
    endsequence
    sequence s_answer;
        bus_rvalid;
    endsequence
    property p_rd_answer;
        s_read |=> s_answer;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_answer;
        !bus_req.rd |=> !bus_rvalid;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without read");
    property p_idle_zero;
        !bus_rvalid |-> bus_rdata == 32'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
    property p_step_top;
        bus_rvalid && ($past(bus_req.addr) inside {8'hD0, 8'hD3}) |-> bus_rdata[31:25] == 7'h0;
    endproperty
    a_step_top: assert property (p_step_top) else $error("step unused bits set");
    property p_ofs_top;
        bus_rvalid && ($past(bus_req.addr) inside {8'hD1, 8'hD2, 8'hD4, 8'hD5})
            |-> bus_rdata[31:16] == 16'h0;
    endproperty
    a_ofs_top: assert property (p_ofs_top) else $error("offset unused bits set");
    property p_unmapped;
        bus_rvalid && !($past(bus_req.addr) inside {[8'hD0:8'hD5]}) |-> bus_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_tx_stamp;
        tx_stamp_valid |=> tx_corr_valid;
    endproperty
    a_tx_stamp: assert property (p_tx_stamp) else $error("tx stamp lost");
    property p_rx_stamp;
        rx_stamp_valid |=> rx_corr_valid;
    endproperty
    a_rx_stamp: assert property (p_rx_stamp) else $error("rx stamp lost");
    property p_tx_hold;
        !tx_corr_valid |-> $stable(tx_corr_stamp);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx stamp moved");
    property p_rx_hold;
        !rx_corr_valid |-> $stable(rx_corr_stamp);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx stamp moved");
    property p_tx_quiet;
        !tx_stamp_valid |=> !tx_corr_valid;
    endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("tx valid without stamp");
    property p_rx_quiet;
        !rx_stamp_valid |=> !rx_corr_valid;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("rx valid without stamp");
endmodule
bind tsc_correction_regs tsc_regs_props chk_u (.ref_clk, .rst_b, .bus_req, .bus_rdata,
    .bus_rvalid, .tx_stamp_valid, .rx_stamp_valid, .tx_corr_valid, .rx_corr_valid, .tx_corr_stamp,
    .rx_corr_stamp);
`default_nettype wire

//--- timestamp_correction_regs_tb_top.sv
// self-checking bench for the timestamp correction register bank
// assumes tsc_correction_regs and its checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module timestamp_correction_regs_tb_top;
    import tsc_pkg::*;
    localparam int UI_PS = 800;
    logic ref_clk = 1'b0, rst_b = 1'b0, tv = 1'b0, rv = 1'b0, rvalid, tcv, rcv;
    tsc_bus_req_t req = '0;
    tsc_stamp_t ts = '0, rs = '0, tc, rc;
    logic [31:0] rdata;
    logic [3:0] txn = 4'h0, rxn = 4'h0;
    int err_count = 0, check_count = 0;
    logic [7:0] idx [6] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5};
    logic [31:0] msk [6] = '{32'h01FFFFFF, 32'h0000FFFF, 32'h0000FFFF,
        32'h01FFFFFF, 32'h0000FFFF, 32'h0000FFFF};
    tsc_correction_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(req),
        .bus_rdata(rdata), .bus_rvalid(rvalid), .tx_stage_count(txn), .rx_stage_count(rxn),
        .tx_stamp_valid(tv), .tx_stamp_in(ts), .rx_stamp_valid(rv), .rx_stamp_in(rs),
        .tx_corr_valid(tcv), .tx_corr_stamp(tc), .rx_corr_valid(rcv), .rx_corr_stamp(rc));
    // ****************
    // tasks, entered at a falling edge except end_of_test from the watchdog, which runs at a rising edge
    // ****************
    task cmp(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // idle cycle after each access so a strobe never toggles twice in one step
    task wr(input logic [7:0] a, input logic [31:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk);
        req.wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge ref_clk);
        req.rd = 1'b0;
        cmp({47'h0, rvalid}, 48'h1);
        cmp({16'h0, rdata}, {16'h0, e});
        @(negedge ref_clk);
    endtask
    task stamp(input logic d, input tsc_stamp_t s, input logic [47:0] e);
        if (d) begin
            rv = 1'b1;
            rs = s;
        end else begin
            tv = 1'b1;
            ts = s;
        end
        @(negedge ref_clk);
        tv = 1'b0;
        rv = 1'b0;
        cmp({47'h0, d ? rcv : tcv}, 48'h1);
        cmp(d ? rc : tc, e);
        @(negedge ref_clk);
    endtask
    // ****************
    // clock, watchdog, sequence
    // ****************
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        end_of_test;
    end
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        foreach (idx[i]) rd(idx[i], 32'h0);
        foreach (idx[i]) wr(idx[i], 32'hFFFFFFFF);
        foreach (idx[i]) rd(idx[i], msk[i]);
        wr(8'hD6, 32'hFFFFFFFF);
        rd(8'hD6, 32'h0);
        wr(8'hD0, 32'h00080000);
        wr(8'hD1, 32'h00008000);
        wr(8'hD2, 32'h00000005);
        txn = 4'h3;
        // 100.5 + 3 x 8 + 5.5 carries into whole ns
        stamp(1'b0, {32'h64, 16'h8000}, {32'h82, 16'h0});
        // software side holds a byte address and turns it into the dword offset
        rd(8'(12'h340 / TSC_BYTES_PER_REG), 32'h00080000);
        wr(8'hD3, 32'h00014000);
        wr(8'hD4, 32'h0);
        // a 15 UI link delay at 800 ps per UI is a whole 12 ns offset
        wr(8'hD5, 32'(15 * UI_PS / 1000));
        rxn = 4'h2;
        // the sum wraps past the top of the ns range
        stamp(1'b1, {32'hFFFFFFFF, 16'h8000}, {32'(2 + 15 * UI_PS / 1000), 16'h0});
        rst_b = 1'b0;
        @(negedge ref_clk);
        rst_b = 1'b1;
        foreach (idx[i]) rd(idx[i], 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
